// ===== logic/pic_top.sv
// prioritized interrupt controller with avalon-mm register slave
`timescale 1ns/1ps
`include "pic_params.svh"
module pic_top (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic avs_response_err,
    input wire logic [`PIC_NUM_SRC-1:0] periph_req,
    input wire logic [`PIC_EXT_EDGE_W-1:0] ext_irq_in,
    input wire logic [4:0] trap_event,
    input wire logic dma_trap_event,
    input wire logic loop_trap_event,
    input wire logic soft_hard_trap_event,
    input wire logic cpu_ack,
    output logic cpu_irq_req,
    output logic [7:0] cpu_vector,
    output logic [3:0] cpu_new_level,
    output logic nesting_disable,
    output logic irq
);
    logic [`PIC_NUM_SRC-1:0] flag_q;
    logic [`PIC_NUM_SRC-1:0] enable_q;
    logic [3*`PIC_NUM_SRC-1:0] prio_q;
    logic [7:0] pend_vec_q;
    logic [3:0] pend_lvl_q;
    logic [15:0] ctrl1_q;
    logic [15:0] ctrl2_q;
    logic [15:0] ctrl3_q;
    logic [15:0] ctrl4_q;
    logic [2:0] lvl_lo_q;
    logic lvl_top_q;
    logic [3:0] irq_stat_q;
    logic [3:0] irq_mask_q;
    logic [31:0] rdata_q;
    logic err_q;
    pic_pkg::pic_bus_state_t bus_q;
    logic [`PIC_EXT_EDGE_W-1:0] ext_pulse;
    logic [`PIC_NUM_SRC-1:0] src_set;
    logic [`PIC_NUM_SRC-1:0] eligible;
    pic_pkg::pic_level_t win_level;
    logic [3:0] win_index;
    logic win_valid;
    logic wr_hit;
    logic acc_take;
    logic [31:0] wmask;
    logic [31:0] wval;
    logic [3:0] cur_level;
    logic present;
    logic [3:0] irq_event;

    pic_edge_detect u_edge (
        .ref_clk(ref_clk),
        .reset(reset),
        .ext_in(ext_irq_in),
        .falling_sel(ctrl2_q[2:0]),
        .ext_pulse(ext_pulse)
    );

    // external inputs occupy the lowest bits, so external zero lands on bit 0
    assign src_set = periph_req | {{(`PIC_NUM_SRC-`PIC_EXT_EDGE_W){1'b0}}, ext_pulse};
    assign cur_level = {lvl_top_q, lvl_lo_q};
    assign eligible = ctrl2_q[`PIC_BIT_GLOBAL_EN_POS] ? (flag_q & enable_q) : '0;

    pic_arbiter u_arb (
        .req(eligible),
        .prio(prio_q),
        .win_level(win_level),
        .win_index(win_index),
        .win_valid(win_valid)
    );

    assign present = win_valid && (win_level > cur_level);

    // bus: one wait cycle; read data is fetched in it, a write lands on the edge after it
    assign acc_take = (avs_read || avs_write) && (bus_q == pic_pkg::PIC_BUS_IDLE);
    assign wr_hit = avs_write && (bus_q == pic_pkg::PIC_BUS_ACK);
    assign avs_waitrequest = acc_take;
    assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign wval = avs_writedata & wmask;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            bus_q <= pic_pkg::PIC_BUS_IDLE;
        end else begin
            case (bus_q)
                pic_pkg::PIC_BUS_IDLE: if (avs_read || avs_write) bus_q <= pic_pkg::PIC_BUS_ACK;
                pic_pkg::PIC_BUS_ACK: bus_q <= pic_pkg::PIC_BUS_IDLE;
                default: bus_q <= pic_pkg::PIC_BUS_IDLE;
            endcase
        end
    end

    // set beats clear: a new request in the clearing cycle survives
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            flag_q <= '0;
        end else if (wr_hit && avs_address == `PIC_OFF_FLAG) begin
            flag_q <= (flag_q & ~wmask[`PIC_NUM_SRC-1:0]) | wval[`PIC_NUM_SRC-1:0]
                      | src_set;
        end else begin
            flag_q <= flag_q | src_set;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            enable_q <= '0;
        end else if (wr_hit && avs_address == `PIC_OFF_ENABLE) begin
            enable_q <= (enable_q & ~wmask[`PIC_NUM_SRC-1:0]) | wval[`PIC_NUM_SRC-1:0];
        end
    end

    // four 3-bit fields per 16-bit half, bit 3 of each nibble reserved
    genvar g;
    generate
        for (g = 0; g < `PIC_NUM_SRC; g++) begin : g_prio
            localparam logic [7:0] OFF = (g < 8) ? `PIC_OFF_PRIO0 : `PIC_OFF_PRIO1;
            localparam int POS = (g % 8) * 4;
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    prio_q[3*g +: 3] <= `PIC_RESET_PRIO;
                end else if (wr_hit && avs_address == OFF && avs_byteenable[POS/8]) begin
                    prio_q[3*g +: 3] <= avs_writedata[POS +: 3];
                end
            end
        end
    endgenerate

    // latch the winner; the core consumes it with cpu_ack
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pend_vec_q <= 8'h00;
            pend_lvl_q <= 4'h0;
        end else if (present) begin
            pend_vec_q <= `PIC_VEC_BASE + {4'h0, win_index};
            pend_lvl_q <= win_level;
        end
    end

    assign cpu_irq_req = present;
    assign cpu_vector = pend_vec_q;
    assign cpu_new_level = pend_lvl_q;

    // cpu level: acceptance raises it; software writes only the low bits
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            lvl_lo_q <= 3'h0;
            lvl_top_q <= 1'b0;
        end else if (cpu_ack) begin
            lvl_lo_q <= pend_lvl_q[2:0];
            lvl_top_q <= pend_lvl_q[3];
        end else if (wr_hit && avs_address == `PIC_OFF_STATUS && avs_byteenable[0]) begin
            lvl_lo_q <= avs_writedata[`PIC_LVL_LO_POS +: 3];
        end
    end

    // trap flags: hardware sets, writing zero clears, a set in the same cycle wins
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ctrl1_q <= `PIC_RESET_STATUS;
        end else begin
            if (wr_hit && avs_address == `PIC_OFF_CTRL1) begin
                ctrl1_q <= (avs_writedata[15:0] & ctrl1_q)
                           | {avs_writedata[15], 10'h000, trap_event};
            end else begin
                ctrl1_q <= ctrl1_q | {11'h000, trap_event};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ctrl2_q <= `PIC_RESET_CTRL2;
        end else if (wr_hit && avs_address == `PIC_OFF_CTRL2) begin
            ctrl2_q <= {avs_writedata[15], 12'h000, avs_writedata[2:0]};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ctrl3_q <= `PIC_RESET_STATUS;
        end else begin
            if (wr_hit && avs_address == `PIC_OFF_CTRL3) begin
                ctrl3_q <= avs_writedata[15:0] & ctrl3_q;
            end else begin
                ctrl3_q <= ctrl3_q;
            end
            if (dma_trap_event) ctrl3_q[`PIC_BIT_DMA_TRAP_POS] <= 1'b1;
            if (loop_trap_event) ctrl3_q[`PIC_BIT_LOOP_TRAP_POS] <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ctrl4_q <= `PIC_RESET_STATUS;
        end else if (soft_hard_trap_event) begin
            ctrl4_q[`PIC_BIT_SOFT_TRAP_POS] <= 1'b1;
        end else if (wr_hit && avs_address == `PIC_OFF_CTRL4) begin
            ctrl4_q[`PIC_BIT_SOFT_TRAP_POS] <= avs_writedata[`PIC_BIT_SOFT_TRAP_POS] & ctrl4_q[0];
        end
    end

    assign nesting_disable = ctrl1_q[`PIC_BIT_NEST_OFF_POS];

    // summary interrupt: any trap_event, dma or loop trap, software trap, new pending
    assign irq_event = {present, soft_hard_trap_event, dma_trap_event | loop_trap_event,
                        |trap_event};

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irq_stat_q <= 4'h0;
        end else if (wr_hit && avs_address == `PIC_OFF_IRQ_STAT && avs_byteenable[0]) begin
            irq_stat_q <= (irq_stat_q & ~avs_writedata[3:0]) | irq_event;
        end else begin
            irq_stat_q <= irq_stat_q | irq_event;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irq_mask_q <= 4'h0;
        end else if (wr_hit && avs_address == `PIC_OFF_IRQ_MASK && avs_byteenable[0]) begin
            irq_mask_q <= avs_writedata[3:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |((irq_stat_q | irq_event) & irq_mask_q);
        end
    end

    // read data captured in the wait cycle, shown with waitrequest low
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdata_q <= 32'h00000000;
            err_q <= 1'b0;
        end else if (acc_take) begin
            err_q <= 1'b0;
            rdata_q <= 32'h00000000;
            case (avs_address)
                `PIC_OFF_FLAG: rdata_q <= {16'h0000, flag_q};
                `PIC_OFF_ENABLE: rdata_q <= {16'h0000, enable_q};
                `PIC_OFF_PRIO0: rdata_q <= {1'b0, prio_q[21 +: 3], 1'b0, prio_q[18 +: 3],
                    1'b0, prio_q[15 +: 3], 1'b0, prio_q[12 +: 3], 1'b0, prio_q[9 +: 3],
                    1'b0, prio_q[6 +: 3], 1'b0, prio_q[3 +: 3], 1'b0, prio_q[0 +: 3]};
                `PIC_OFF_PRIO1: rdata_q <= {1'b0, prio_q[45 +: 3], 1'b0, prio_q[42 +: 3],
                    1'b0, prio_q[39 +: 3], 1'b0, prio_q[36 +: 3], 1'b0, prio_q[33 +: 3],
                    1'b0, prio_q[30 +: 3], 1'b0, prio_q[27 +: 3], 1'b0, prio_q[24 +: 3]};
                `PIC_OFF_PENDING: rdata_q <= {20'h00000, pend_lvl_q, pend_vec_q};
                `PIC_OFF_CTRL1: rdata_q <= {16'h0000, ctrl1_q};
                `PIC_OFF_CTRL2: rdata_q <= {16'h0000, ctrl2_q};
                `PIC_OFF_CTRL3: rdata_q <= {16'h0000, ctrl3_q};
                `PIC_OFF_CTRL4: rdata_q <= {16'h0000, ctrl4_q};
                `PIC_OFF_STATUS: rdata_q <= {24'h000000, lvl_lo_q, 5'h00};
                `PIC_OFF_CORE: rdata_q <= {28'h0000000, lvl_top_q, 3'h0};
                `PIC_OFF_IRQ_STAT: rdata_q <= {28'h0000000, irq_stat_q};
                `PIC_OFF_IRQ_MASK: rdata_q <= {28'h0000000, irq_mask_q};
                default: err_q <= 1'b1;
            endcase
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_response_err = err_q && (bus_q == pic_pkg::PIC_BUS_ACK);
endmodule : pic_top

// ===== pkg/pic_params.svh
// constants for the prioritized interrupt controller
`ifndef PIC_PARAMS_SVH
`define PIC_PARAMS_SVH
`define PIC_NUM_SRC 16
`define PIC_VEC_BASE 8'h08
`define PIC_OFF_FLAG 8'h00
`define PIC_OFF_ENABLE 8'h04
`define PIC_OFF_PRIO0 8'h08
`define PIC_OFF_PRIO1 8'h0C
`define PIC_OFF_PENDING 8'h10
`define PIC_OFF_CTRL1 8'h14
`define PIC_OFF_CTRL2 8'h18
`define PIC_OFF_CTRL3 8'h1C
`define PIC_OFF_CTRL4 8'h20
`define PIC_OFF_STATUS 8'h24
`define PIC_OFF_CORE 8'h28
`define PIC_OFF_IRQ_STAT 8'h2C
`define PIC_OFF_IRQ_MASK 8'h30
`define PIC_BIT_NEST_OFF_POS 15
`define PIC_BIT_GLOBAL_EN_POS 15
`define PIC_BIT_SOFT_TRAP_POS 0
`define PIC_BIT_DMA_TRAP_POS 5
`define PIC_BIT_LOOP_TRAP_POS 4
`define PIC_LVL_LO_POS 5
`define PIC_LVL_TOP_POS 3
`define PIC_EXT_EDGE_W 3
`define PIC_RESET_STATUS 16'h0000
`define PIC_RESET_CTRL2 16'h0000
`define PIC_RESET_PRIO 3'h4
`endif

// ===== pkg/pic_pkg.sv
// types for the prioritized interrupt controller
package pic_pkg;
    typedef logic [2:0] pic_prio_t;
    typedef logic [3:0] pic_level_t;
    typedef logic [7:0] pic_vec_t;
    typedef enum logic [1:0] {
        PIC_BUS_IDLE = 2'b00,
        PIC_BUS_ACK = 2'b01
    } pic_bus_state_t;
endpackage : pic_pkg

// ===== logic/pic_arbiter.sv
// priority arbiter: highest level, lowest vector on ties
`timescale 1ns/1ps
`include "pic_params.svh"
module pic_arbiter (
    input wire logic [`PIC_NUM_SRC-1:0] req,
    input wire logic [3*`PIC_NUM_SRC-1:0] prio,
    output pic_pkg::pic_level_t win_level,
    output logic [3:0] win_index,
    output logic win_valid
);
    // scan high to low so a lower index with an equal level overwrites
    always_comb begin
        win_level = 4'h0;
        win_index = 4'h0;
        win_valid = 1'b0;
        for (int i = `PIC_NUM_SRC - 1; i >= 0; i--) begin
            if (req[i] && ({1'b0, prio[3*i +: 3]} >= win_level) && prio[3*i +: 3] != 3'h0) begin
                win_level = {1'b0, prio[3*i +: 3]};
                win_index = 4'(i);
                win_valid = 1'b1;
            end
        end
    end
endmodule : pic_arbiter

// ===== logic/pic_edge_detect.sv
// per-input rising or falling edge capture for external inputs
`timescale 1ns/1ps
`include "pic_params.svh"
module pic_edge_detect (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [`PIC_EXT_EDGE_W-1:0] ext_in,
    input wire logic [`PIC_EXT_EDGE_W-1:0] falling_sel,
    output logic [`PIC_EXT_EDGE_W-1:0] ext_pulse
);
    logic [`PIC_EXT_EDGE_W-1:0] prev_q;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            // load the pin itself so a pin already high gives no false edge after reset
            prev_q <= ext_in;
        end else begin
            prev_q <= ext_in;
        end
    end
    genvar g;
    generate
        for (g = 0; g < `PIC_EXT_EDGE_W; g++) begin : g_edge
            // polarity per input selected in the second global control register
            assign ext_pulse[g] = falling_sel[g] ? (prev_q[g] & ~ext_in[g])
                                                 : (~prev_q[g] & ext_in[g]);
        end
    endgenerate
endmodule : pic_edge_detect

// ===== tb/pic_checker.sv
// port assertions for the prioritized interrupt controller
`timescale 1ns/1ps
module pic_checker (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic avs_response_err,
    input wire logic cpu_irq_req,
    input wire logic [7:0] cpu_vector,
    input wire logic [3:0] cpu_new_level,
    input wire logic nesting_disable
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    a_wait_first_cycle: assert property (
        (avs_read || avs_write) && !$past(avs_read) && !$past(avs_write) |-> avs_waitrequest)
        else $error("access answered without a wait cycle");
    a_wait_one_cycle: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("access not answered after one wait cycle");
    a_err_with_answer: assert property (
        avs_response_err |-> (avs_read || avs_write) && !avs_waitrequest)
        else $error("error flag outside an answer");
    a_err_zero_data: assert property (
        avs_response_err && avs_read |-> avs_readdata == 32'h0)
        else $error("refused read returned data");
    // read data must not drift between accesses, software may read it late
    a_rdata_hold: assert property (!avs_read && !avs_write |=> $stable(avs_readdata))
        else $error("read data changed while idle");
    a_nest_by_write: assert property (
        $changed(nesting_disable) |-> $past(avs_write))
        else $error("nesting disable changed without a write");
    a_vector_range: assert property (
        $rose(cpu_irq_req) |-> ##1 cpu_vector >= 8'h08 && cpu_vector <= 8'h17)
        else $error("vector outside the source range");
    a_level_range: assert property (
        $rose(cpu_irq_req) |-> ##1 cpu_new_level != 4'h0 && !cpu_new_level[3])
        else $error("new level not a user priority");
endmodule : pic_checker
bind pic_top pic_checker u_chk (.ref_clk(ref_clk), .reset(reset), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response_err(avs_response_err), .cpu_irq_req(cpu_irq_req),
    .cpu_vector(cpu_vector), .cpu_new_level(cpu_new_level), .nesting_disable(nesting_disable));

// ===== tb/pic_core_model.sv
// processor core stand-in that takes vectors from the controller
`timescale 1ns/1ps
module pic_core_model (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic ack_en,
    input wire logic [3:0] ack_dly,
    input wire logic cpu_irq_req,
    input wire logic [7:0] cpu_vector,
    output logic cpu_ack,
    output logic [7:0] taken_vec_q
);
    logic [3:0] wait_q;
    // a busy pipeline takes the vector late, so the delay is adjustable
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wait_q <= 4'h0;
            cpu_ack <= 1'b0;
            taken_vec_q <= 8'h00;
        end else begin
            cpu_ack <= 1'b0;
            if (!ack_en || !cpu_irq_req || cpu_ack) begin
                wait_q <= 4'h0;
            end else if (wait_q == ack_dly) begin
                cpu_ack <= 1'b1;
                taken_vec_q <= cpu_vector;
            end else begin
                wait_q <= wait_q + 4'h1;
            end
        end
    end
endmodule : pic_core_model

// ===== tb/prioritized_interrupt_controller_tb.sv
// self-checking bench for the prioritized interrupt controller
`timescale 1ns/1ps
module prioritized_interrupt_controller_tb;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] m; logic [31:0] x;
        logic e;} pic_row_t;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [15:0] periph_req = 16'h0;
    logic [2:0] ext_irq_in = 3'h0;
    logic [4:0] trap_event = 5'h0;
    logic dma_trap_event = 1'b0;
    logic loop_trap_event = 1'b0;
    logic soft_hard_trap_event = 1'b0;
    logic ack_en = 1'b0;
    logic [3:0] ack_dly = 4'h1;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, avs_response_err, cpu_ack, cpu_irq_req, nesting_disable, irq;
    logic [7:0] cpu_vector, taken_vec;
    logic [3:0] cpu_new_level;
    logic [31:0] q;
    logic e;
    int error_cnt = 0;
    int samples_checked = 0;
    pic_row_t rows [8] = '{'{8'h04, 32'hFFFF, 32'hFFFF, 32'hFFFF, 1'b0},
        '{8'h08, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h77777777, 1'b0},
        '{8'h0C, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b0}, '{8'h24, 32'hE0, 32'hE0, 32'hE0, 1'b0},
        '{8'h28, 32'hFFFF, 32'h8, 32'h0, 1'b0}, '{8'h14, 32'h8000, 32'h8000, 32'h8000, 1'b0},
        '{8'h18, 32'h8000, 32'h8000, 32'h8000, 1'b0},
        '{8'h40, 32'h12345678, 32'hFFFFFFFF, 32'h0, 1'b1}};
    initial forever #10 ref_clk = ~ref_clk;
    pic_top u_dut (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .avs_response_err(avs_response_err), .periph_req(periph_req), .ext_irq_in(ext_irq_in),
        .trap_event(trap_event), .dma_trap_event(dma_trap_event),
        .loop_trap_event(loop_trap_event), .soft_hard_trap_event(soft_hard_trap_event),
        .cpu_ack(cpu_ack), .cpu_irq_req(cpu_irq_req), .cpu_vector(cpu_vector),
        .cpu_new_level(cpu_new_level), .nesting_disable(nesting_disable), .irq(irq));
    pic_core_model u_core (.ref_clk(ref_clk), .reset(reset), .ack_en(ack_en),
        .ack_dly(ack_dly), .cpu_irq_req(cpu_irq_req), .cpu_vector(cpu_vector),
        .cpu_ack(cpu_ack), .taken_vec_q(taken_vec));
    task automatic conclude();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // the request stands until waitrequest is seen low at a rising edge; data is taken there
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rq, output logic re);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        rq = avs_readdata;
        re = avs_response_err;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, q, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        bus(1'b0, a, 32'h0, q, e);
        chk(q & m, x);
    endtask : rd
    task automatic settle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : settle
    initial begin
        #400000;
        error_cnt++;
        conclude();
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].m, rows[i].x);
            chk(e, rows[i].e);
        end
        chk(nesting_disable, 32'h1);
        reset <= 1'b1;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        rd(8'h08, 32'hFFFFFFFF, 32'h44444444);
        chk(nesting_disable, 32'h0);
        wr(8'h04, 32'h000E);
        wr(8'h08, 32'h0660);
        wr(8'h18, 32'h8000);
        periph_req <= 16'h000E;
        @(posedge ref_clk);
        periph_req <= 16'h0;
        settle(3);
        chk({cpu_irq_req, cpu_new_level, cpu_vector}, 32'h1609);
        rd(8'h00, 32'hFFFF, 32'h000E);
        rd(8'h10, 32'hFFF, 32'h609);
        wr(8'h08, 32'h0760);
        settle(3);
        chk({cpu_irq_req, cpu_new_level, cpu_vector}, 32'h170A);
        wr(8'h24, 32'hE0);
        settle(3);
        chk(cpu_irq_req, 32'h0);
        wr(8'h24, 32'h0);
        wr(8'h18, 32'h0);
        settle(3);
        chk(cpu_irq_req, 32'h0);
        wr(8'h18, 32'h8000);
        wr(8'h00, 32'h0);
        rd(8'h00, 32'hFFFF, 32'h0);
        wr(8'h04, 32'h1);
        wr(8'h08, 32'h3);
        ack_en <= 1'b1;
        ext_irq_in <= 3'h1;
        settle(10);
        chk({cpu_irq_req, taken_vec}, 32'h08);
        rd(8'h24, 32'hE0, 32'h60);
        {trap_event, dma_trap_event, loop_trap_event, soft_hard_trap_event} <= 8'hFF;
        @(posedge ref_clk);
        {trap_event, dma_trap_event, loop_trap_event, soft_hard_trap_event} <= 8'h00;
        rd(8'h14, 32'h1F, 32'h1F);
        rd(8'h1C, 32'h30, 32'h30);
        rd(8'h20, 32'h1, 32'h1);
        wr(8'h30, 32'h0);
        settle(2);
        chk(irq, 32'h0);
        wr(8'h30, 32'hF);
        settle(2);
        chk(irq, 32'h1);
        wr(8'h2C, 32'h7);
        rd(8'h2C, 32'h7, 32'h0);
        periph_req <= 16'h0010;
        wr(8'h00, 32'h0);
        periph_req <= 16'h0000;
        rd(8'h00, 32'h10, 32'h10);
        wr(8'h18, 32'h8002);
        ext_irq_in <= 3'h3;
        rd(8'h00, 32'h2, 32'h0);
        ext_irq_in <= 3'h1;
        rd(8'h00, 32'h2, 32'h2);
        avs_byteenable <= 4'h1;
        wr(8'h0C, 32'h7777);
        avs_byteenable <= 4'hF;
        rd(8'h0C, 32'hFFFFFFFF, 32'h44444477);
        conclude();
    end
endmodule : prioritized_interrupt_controller_tb
